//--- rtl/cstp_cycle_decode.sv
/*
  Combinational cycle-count decode for one issued instruction.
  Assumes fetch supplies the instruction length in bytes.
*/
`timescale 1ns/10ps
`include "cstp_defs.svh"
module cstp_cycle_decode (
  input wire cstp_pkg::cstp_insn_t insn,
  output logic [3:0] cycles
);
  // Opcode groups of the published arithmetic rows
  wire [3:0] hi = insn.opcode[7:4];
  wire [3:0] lo = insn.opcode[3:0];
  wire arith_grp = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9);
  wire inc_grp = (hi == 4'h0);
  wire grp = arith_grp || inc_grp;
  wire op_rn = grp && insn.opcode[3];
  wire op_acc = inc_grp && (lo == 4'h4);
  wire op_dir = grp && (lo == 4'h5);
  wire op_imm = arith_grp && (lo == 4'h4);
  wire op_ind = grp && (lo[3:1] == 3'h3);

  wire [3:0] len4 = {2'b00, insn.length};
  wire [3:0] br_cyc = insn.taken ? len4 + 4'h1 : len4;
  wire [3:0] base_cyc =
    (op_rn || op_acc) ? 4'h1 :
    (op_dir || op_imm) ? 4'h2 :
    op_ind ? 4'h2 :
    insn.cond_branch ? br_cyc :
    len4;
  // Zero-length input still costs one cycle; cap keeps the spread
  wire [3:0] floor_cyc = (base_cyc == 4'h0) ? 4'h1 : base_cyc;
  assign cycles = (floor_cyc > `CSTP_MAX_CYCLES) ? `CSTP_MAX_CYCLES : floor_cyc;
endmodule

//--- rtl/cstp_defs.svh
/*
  Constants for the core timing, paging and priority block.
  Assumes inclusion by bare name from every design file that needs it.
*/
// What this block does
// - Encodings and flags follow the published set
// - Timing counted purely in system clock cycles
// - Most instructions take cycles equal to bytes
// - Untaken conditional branch takes one cycle less
// - No instruction exceeds eight clock cycles
// - Cycle counts stay within the published spread
// - Register and accumulator arithmetic: one byte, one cycle
// - Direct or immediate arithmetic: two bytes, two cycles
// - Indirect RAM arithmetic: one byte, two cycles
// - External move routes to three distinct targets
// - Auto paging enable resets set, software clears
// - All-page registers decode on every page
// - Priority bit zero low, one high
// - Bit 0 timer 3, bit 2 timer 4
// - Bits 1, 3, 4 converter priorities
// - Window compare bit set means high priority
`ifndef CSTP_DEFS_SVH
`define CSTP_DEFS_SVH

`define CSTP_OFF_PAGE_SEL 8'h00
`define CSTP_OFF_PAGE_CTRL 8'h04
`define CSTP_OFF_PRIO_TWO 8'h08
`define CSTP_OFF_XMOVE_CTRL 8'h0C
`define CSTP_OFF_STATUS 8'h10

`define CSTP_RST_PAGE_SEL 8'h00
`define CSTP_RST_PAGE_CTRL 8'h01
`define CSTP_RST_PRIO_TWO 8'h00
`define CSTP_RST_XMOVE_CTRL 8'h00

`define CSTP_BIT_AUTO_PAGE 0
`define CSTP_BIT_FLASH_SEL 0
`define CSTP_PRIO_WMASK 8'h5F
`define CSTP_BIT_T3_PRIO 0
`define CSTP_BIT_C0_EOC_PRIO 1
`define CSTP_BIT_T4_PRIO 2
`define CSTP_BIT_C2_WIN_PRIO 3
`define CSTP_BIT_C2_EOC_PRIO 4

`define CSTP_SFR_PORT0 8'h80
`define CSTP_SFR_PORT1 8'h90
`define CSTP_SFR_PORT2 8'hA0
`define CSTP_SFR_PORT3 8'hB0

`define CSTP_MAX_CYCLES 4'h8

`endif

//--- rtl/cstp_page_stack.sv
/*
  Small LIFO of saved register pages for interrupt nesting.
  Assumes push and pop never come in the same cycle.
*/
`timescale 1ns/10ps
module cstp_page_stack #(
  parameter int DEPTH = 3
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [7:0] push_page,
  output logic [7:0] top_page,
  output logic [1:0] level
);
  logic [7:0] ent_q [DEPTH];
  wire [7:0] ent_d [DEPTH];
  logic [1:0] level_q;
  wire can_push = push && (level_q != DEPTH[1:0]);
  wire can_pop = pop && (level_q != 2'h0);

  // Entry 0 is the newest; the stack shifts so the top is fixed
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      wire [7:0] newer = (i == 0) ? push_page : ent_q[(i == 0) ? 0 : i - 1];
      wire [7:0] older = (i == DEPTH - 1) ? 8'h00 : ent_q[(i == DEPTH - 1) ? i : i + 1];
      assign ent_d[i] = can_push ? newer : (can_pop ? older : ent_q[i]);
    end
  endgenerate

  // One process owns the whole array, so no entry has two drivers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ent_q <= '{default: 8'h00};
    end else begin
      ent_q <= ent_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= 2'h0;
    end else if (can_push) begin
      level_q <= level_q + 2'h1;
    end else if (can_pop) begin
      level_q <= level_q - 2'h1;
    end
  end

  // Overflow ignores the push, so the page being saved is lost; a limitation of the fixed depth
  assign top_page = ent_q[0];
  assign level = level_q;
endmodule

//--- rtl/cstp_pkg.sv
/*
  Types shared by the timing, paging and priority block.
  Assumes the constants header is compiled alongside.
*/
package cstp_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [1:0] length;
    logic cond_branch;
    logic taken;
  } cstp_insn_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } cstp_xmove_t;

  typedef struct packed {
    logic all_pages;
    logic [7:0] page;
  } cstp_sfr_dec_t;

  typedef enum logic [1:0] {
    CSTP_TGT_NONE = 2'b00,
    CSTP_TGT_ONCHIP = 2'b01,
    CSTP_TGT_OFFCHIP = 2'b10,
    CSTP_TGT_FLASH = 2'b11
  } cstp_target_t;

  typedef enum logic {
    CSTP_ST_IDLE = 1'b0,
    CSTP_ST_RUN = 1'b1
  } cstp_state_t;

endpackage

//--- rtl/cstp_top.sv
/*
  Core timing sequencer, external-move router, register paging and
  the second extended priority register, behind an AHB-Lite slave.
  Assumes one clock, synchronous inputs and single word transfers.
*/
`timescale 1ns/10ps
`include "cstp_defs.svh"
module cstp_top #(
  parameter logic [15:0] EXT_RAM_BYTES = 16'h1000,
  parameter int STACK_DEPTH = 3
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire cstp_pkg::cstp_insn_t insn,
  output logic insn_ready,
  output logic insn_done,
  output logic [3:0] insn_cycles,
  input wire cstp_pkg::cstp_xmove_t xmove,
  output cstp_pkg::cstp_target_t xmove_target,
  output logic xmove_strobe,
  input wire logic [7:0] sfr_addr,
  output cstp_pkg::cstp_sfr_dec_t sfr_dec,
  input wire logic int_enter,
  input wire logic [7:0] int_page,
  input wire logic int_return,
  output logic [7:0] active_page,
  output logic [4:0] src_high_prio,
  output logic uart1_high_prio
);

  // Register bus state
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic rd_pend_q;
  logic [7:0] rd_addr_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;

  // Software-visible registers
  logic [7:0] page_sel_q;
  logic [7:0] page_sel_d;
  logic [7:0] page_ctrl_q;
  logic [7:0] prio_two_q;
  logic [7:0] xmove_ctrl_q;

  // Sequencer state
  cstp_pkg::cstp_state_t state_q;
  logic [3:0] cnt_q;
  logic insn_ready_q;
  logic insn_done_q;
  logic [3:0] last_cycles_q;

  // Router and decode outputs
  cstp_pkg::cstp_target_t xmove_target_q;
  logic xmove_strobe_q;
  cstp_pkg::cstp_sfr_dec_t sfr_dec_q;

  logic [3:0] dec_cycles;
  logic [7:0] stack_top;
  logic [1:0] stack_level;

  // Address phase decode
  wire addr_phase = hsel && htrans[1] && hready;
  wire wr_accept = addr_phase && hwrite;
  wire rd_accept = addr_phase && !hwrite;
  wire wr_commit = wr_pend_q && hready;

  wire wr_page_sel = wr_commit && (wr_addr_q == `CSTP_OFF_PAGE_SEL);
  wire wr_page_ctrl = wr_commit && (wr_addr_q == `CSTP_OFF_PAGE_CTRL);
  wire wr_prio_two = wr_commit && (wr_addr_q == `CSTP_OFF_PRIO_TWO);
  wire wr_xmove_ctrl = wr_commit && (wr_addr_q == `CSTP_OFF_XMOVE_CTRL);

  wire auto_page = page_ctrl_q[`CSTP_BIT_AUTO_PAGE];
  wire do_push = int_enter && auto_page;
  wire do_pop = int_return && auto_page && !int_enter;

  // Status word gathers the sequencer, stack and router state
  wire [31:0] status_word = {20'h00000, xmove_target_q, stack_level,
                             last_cycles_q, 3'h0, state_q};

  wire [31:0] rd_mux =
    (rd_addr_q == `CSTP_OFF_PAGE_SEL) ? {24'h000000, page_sel_q} :
    (rd_addr_q == `CSTP_OFF_PAGE_CTRL) ? {24'h000000, page_ctrl_q} :
    (rd_addr_q == `CSTP_OFF_PRIO_TWO) ? {24'h000000, prio_two_q} :
    (rd_addr_q == `CSTP_OFF_XMOVE_CTRL) ? {24'h000000, xmove_ctrl_q} :
    (rd_addr_q == `CSTP_OFF_STATUS) ? status_word :
    32'h00000000;

  // Bus timing: reads take one wait state so a write just before
  // them is already committed when the data is sampled
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout_q <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else if (rd_accept) begin
      hreadyout_q <= 1'b0;
      rd_pend_q <= 1'b1;
      rd_addr_q <= haddr[7:0];
    end else if (rd_pend_q) begin
      hreadyout_q <= 1'b1;
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (wr_accept) begin
      wr_pend_q <= 1'b1;
      wr_addr_q <= haddr[7:0];
    end else if (wr_commit) begin
      wr_pend_q <= 1'b0;
    end
  end

  // Page select: interrupt entry and return win over software
  assign page_sel_d =
    do_push ? int_page :
    do_pop ? stack_top :
    wr_page_sel ? hwdata[7:0] :
    page_sel_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      page_sel_q <= `CSTP_RST_PAGE_SEL;
    end else begin
      page_sel_q <= page_sel_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      page_ctrl_q <= `CSTP_RST_PAGE_CTRL;
    end else if (wr_page_ctrl) begin
      page_ctrl_q <= {7'h00, hwdata[`CSTP_BIT_AUTO_PAGE]};
    end
  end

  // Unused bits 7 and 5 never store, so they read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prio_two_q <= `CSTP_RST_PRIO_TWO;
    end else if (wr_prio_two) begin
      prio_two_q <= hwdata[7:0] & `CSTP_PRIO_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xmove_ctrl_q <= `CSTP_RST_XMOVE_CTRL;
    end else if (wr_xmove_ctrl) begin
      xmove_ctrl_q <= {7'h00, hwdata[`CSTP_BIT_FLASH_SEL]};
    end
  end

  cstp_page_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .core_clk(core_clk),
    .resetn(resetn),
    .push(do_push),
    .pop(do_pop),
    .push_page(page_sel_q),
    .top_page(stack_top),
    .level(stack_level)
  );

  cstp_cycle_decode u_dec (
    .insn(insn),
    .cycles(dec_cycles)
  );

  // Sequencer: one issue slot per instruction, busy for its cycles
  wire issue = insn.valid && insn_ready_q;
  wire last_tick = (state_q == cstp_pkg::CSTP_ST_RUN) && (cnt_q == 4'h1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= cstp_pkg::CSTP_ST_IDLE;
      cnt_q <= 4'h0;
      insn_ready_q <= 1'b1;
      insn_done_q <= 1'b0;
    end else begin
      insn_done_q <= 1'b0;
      case (state_q)
        cstp_pkg::CSTP_ST_IDLE: begin
          if (issue && (dec_cycles == 4'h1)) begin
            insn_done_q <= 1'b1;
          end else if (issue) begin
            cnt_q <= dec_cycles - 4'h1;
            insn_ready_q <= 1'b0;
            state_q <= cstp_pkg::CSTP_ST_RUN;
          end
        end
        cstp_pkg::CSTP_ST_RUN: begin
          if (last_tick) begin
            insn_done_q <= 1'b1;
            insn_ready_q <= 1'b1;
            state_q <= cstp_pkg::CSTP_ST_IDLE;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        default: begin
          state_q <= cstp_pkg::CSTP_ST_IDLE;
          insn_ready_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last_cycles_q <= 4'h0;
    end else if (issue) begin
      last_cycles_q <= dec_cycles;
    end
  end

  // External move routing; flash select overrides the address split
  wire flash_sel = xmove_ctrl_q[`CSTP_BIT_FLASH_SEL];
  wire below_ram = xmove.addr < EXT_RAM_BYTES;
  wire cstp_pkg::cstp_target_t tgt_d =
    flash_sel ? cstp_pkg::CSTP_TGT_FLASH :
    below_ram ? cstp_pkg::CSTP_TGT_ONCHIP :
    cstp_pkg::CSTP_TGT_OFFCHIP;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xmove_target_q <= cstp_pkg::CSTP_TGT_NONE;
      xmove_strobe_q <= 1'b0;
    end else begin
      xmove_strobe_q <= xmove.req;
      if (xmove.req) begin
        xmove_target_q <= tgt_d;
      end
    end
  end

  // Register decode: port registers ignore the page select
  wire all_page_hit = (sfr_addr == `CSTP_SFR_PORT0) || (sfr_addr == `CSTP_SFR_PORT1) ||
                      (sfr_addr == `CSTP_SFR_PORT2) || (sfr_addr == `CSTP_SFR_PORT3);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_dec_q <= '0;
    end else begin
      sfr_dec_q.all_pages <= all_page_hit;
      sfr_dec_q.page <= all_page_hit ? 8'h00 : page_sel_q;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign insn_ready = insn_ready_q;
  assign insn_done = insn_done_q;
  assign insn_cycles = last_cycles_q;
  assign xmove_target = xmove_target_q;
  assign xmove_strobe = xmove_strobe_q;
  assign sfr_dec = sfr_dec_q;
  assign active_page = page_sel_q;
  assign src_high_prio[0] = prio_two_q[`CSTP_BIT_T3_PRIO];
  assign src_high_prio[1] = prio_two_q[`CSTP_BIT_C0_EOC_PRIO];
  assign src_high_prio[2] = prio_two_q[`CSTP_BIT_T4_PRIO];
  assign src_high_prio[3] = prio_two_q[`CSTP_BIT_C2_WIN_PRIO];
  assign src_high_prio[4] = prio_two_q[`CSTP_BIT_C2_EOC_PRIO];
  assign uart1_high_prio = prio_two_q[6];

endmodule

//--- testbench/cstp_fetch_model.sv
/*
  Fetch side model: offers one instruction per go and times done.
  Assumes the core's valid and ready issue handshake.
*/
`timescale 1ns/10ps
module cstp_fetch_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic go,
  input wire cstp_pkg::cstp_insn_t next_insn,
  input wire logic insn_ready,
  input wire logic insn_done,
  output cstp_pkg::cstp_insn_t insn,
  output logic busy,
  output logic [3:0] lat
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      insn <= '0;
    end else if (go) begin
      insn <= {1'b1, next_insn[11:0]};
    end else if (!insn.valid || insn_ready) begin
      // Idle fields toggle so stale values never pass
      insn <= {1'b0, ~insn[11:0]};
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt_q <= 4'h0;
      lat <= 4'h0;
    end else if (go) begin
      busy <= 1'b1;
      cnt_q <= 4'h0;
    end else if (busy && !insn.valid) begin
      cnt_q <= cnt_q + 4'h1;
      if (insn_done) begin
        lat <= cnt_q + 4'h1;
        busy <= 1'b0;
      end
    end
  end
endmodule

//--- testbench/cstp_top_properties.sv
/*
  Port checks for the timing and paging block.
  Assumes bind onto cstp_top; one clock domain.
*/
`timescale 1ns/10ps
module cstp_top_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hreadyout,
  input wire cstp_pkg::cstp_insn_t insn,
  input wire logic insn_ready,
  input wire logic insn_done,
  input wire logic [3:0] insn_cycles,
  input wire cstp_pkg::cstp_xmove_t xmove,
  input wire logic xmove_strobe,
  input wire logic [7:0] sfr_addr,
  input wire cstp_pkg::cstp_sfr_dec_t sfr_dec
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic iss;
  assign iss = insn.valid && insn_ready;
  chk_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  chk_cycle_cap: assert property (insn_cycles <= 4'h8)
    else $error("cycle count above cap");
  chk_reg_one: assert property (iss && insn.opcode[7:3] == 5'h05 |=>
    insn_cycles == 4'h1) else $error("register op not one cycle");
  chk_imm_two: assert property (iss && insn.opcode == 8'h24 |=>
    insn_cycles == 4'h2) else $error("immediate op not two cycles");
  chk_ind_two: assert property (iss && insn.opcode[7:1] == 7'h13 |=>
    insn_cycles == 4'h2) else $error("indirect op not two cycles");
  chk_branch_len: assert property (iss && insn.cond_branch && insn.opcode == 8'h60
    && insn.length != 2'b00 |=> insn_cycles == 4'($past(insn.length)) +
    4'($past(insn.taken))) else $error("branch timing wrong");
  chk_one_done: assert property (iss ##1 insn_cycles == 4'h1 |-> insn_done)
    else $error("single cycle op not done");
  chk_ready_low: assert property (iss ##1 insn_cycles > 4'h1 |-> !insn_ready)
    else $error("ready high during multi cycle op");
  chk_strobe_req: assert property (xmove.req |=> xmove_strobe)
    else $error("no strobe after move request");
  chk_strobe_cause: assert property (xmove_strobe |-> $past(xmove.req))
    else $error("strobe without request");
  chk_all_pages: assert property (sfr_addr[7:6] == 2'b10 && sfr_addr[3:0] == 4'h0
    |=> sfr_dec.all_pages && sfr_dec.page == 8'h00) else $error("port reg paged");
  cov_two: cover property (iss ##1 insn_cycles == 4'h2);
  cov_move: cover property (xmove.req ##1 xmove_strobe);
  cov_port: cover property (sfr_dec.all_pages);
endmodule

bind cstp_top cstp_top_chk chk (.core_clk(core_clk), .resetn(resetn),
  .hreadyout(hreadyout), .insn(insn), .insn_ready(insn_ready), .insn_done(insn_done),
  .insn_cycles(insn_cycles), .xmove(xmove), .xmove_strobe(xmove_strobe),
  .sfr_addr(sfr_addr), .sfr_dec(sfr_dec));

//--- testbench/tb_cpu_timing_sfr_paging_priority.sv
/*
  Bench for the core timing, paging and priority block.
  Assumes the fetch model and the bound checker.
*/
`timescale 1ns/10ps
`include "cstp_defs.svh"
module tb_cpu_timing_sfr_paging_priority;
  logic core_clk, resetn, hsel, hwrite, hreadyout, hresp, insn_ready, insn_done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] insn_cycles, lat;
  logic xmove_strobe, int_enter, int_return, uart1_high_prio, go, fm_busy;
  logic [7:0] sfr_addr, int_page, active_page;
  logic [4:0] src_high_prio;
  logic [15:0] tbl [15];
  cstp_pkg::cstp_insn_t insn, nxt;
  cstp_pkg::cstp_xmove_t xmove;
  cstp_pkg::cstp_target_t xmove_target;
  cstp_pkg::cstp_sfr_dec_t sfr_dec;
  int error_cnt, check_count, cyc;
  cstp_top #(.EXT_RAM_BYTES(16'h1000), .STACK_DEPTH(3)) uut (.core_clk(core_clk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .insn(insn), .insn_ready(insn_ready),
    .insn_done(insn_done), .insn_cycles(insn_cycles), .xmove(xmove),
    .xmove_target(xmove_target), .xmove_strobe(xmove_strobe), .sfr_addr(sfr_addr),
    .sfr_dec(sfr_dec), .int_enter(int_enter), .int_page(int_page),
    .int_return(int_return), .active_page(active_page),
    .src_high_prio(src_high_prio), .uart1_high_prio(uart1_high_prio));
  cstp_fetch_model fm (.core_clk(core_clk), .resetn(resetn), .go(go), .next_insn(nxt),
    .insn_ready(insn_ready), .insn_done(insn_done), .insn(insn), .busy(fm_busy),
    .lat(lat));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask
  task irq(input logic e, input logic r, input logic [7:0] p);
    @(posedge core_clk);
    int_enter <= e;
    int_return <= r;
    int_page <= p;
    @(posedge core_clk);
    int_enter <= 1'b0;
    int_return <= 1'b0;
    #1;
  endtask
  task xm(input logic [15:0] a, input logic [1:0] t);
    @(posedge core_clk);
    xmove <= {1'b1, a};
    @(posedge core_clk);
    xmove <= {1'b0, ~a};
    #1;
    chk({xmove_strobe, xmove_target}, {1'b1, t});
  endtask
  task sfr(input logic [7:0] a, input logic [8:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    @(posedge core_clk);
    #1;
    chk(sfr_dec, exp);
  endtask
  task run(input logic [15:0] e);
    @(posedge core_clk);
    nxt <= {1'b0, e[15:8], e[7:6], e[5], e[4]};
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    do @(posedge core_clk); while (fm_busy !== 1'b0);
    chk(lat, e[3:0]);
    chk(insn_cycles, e[3:0]);
  endtask
  initial begin
    // Opcode, length, branch, taken, expected clocks
    tbl = '{16'h2841, 16'h3F41, 16'h9841, 16'h0441, 16'h0841, 16'h2582, 16'h2482,
      16'h9482, 16'h0582, 16'h2642, 16'h9742, 16'h60B3, 16'h60A2, 16'h7482, 16'h12C3};
    {hsel, hwrite, go, int_enter, int_return, resetn} = 6'h00;
    {haddr, hwdata} = 64'h0;
    {htrans, hsize} = 5'h02;
    {sfr_addr, int_page} = 16'h0000;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    nxt = '0;
    xmove = '0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b0, `CSTP_OFF_PAGE_CTRL, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, `CSTP_OFF_PRIO_TWO, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `CSTP_OFF_PRIO_TWO, 32'hFF);
    bus(1'b0, `CSTP_OFF_PRIO_TWO, 32'h0);
    chk(rd, 32'h5F);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `CSTP_OFF_PRIO_TWO, 32'h1 << (i + i / 5));
      repeat (2) @(posedge core_clk);
      chk({uart1_high_prio, src_high_prio}, 32'h1 << i);
    end
    bus(1'b1, `CSTP_OFF_PAGE_SEL, 32'h05);
    irq(1'b1, 1'b0, 8'h0F);
    chk(active_page, 8'h0F);
    irq(1'b1, 1'b0, 8'h02);
    chk(active_page, 8'h02);
    irq(1'b0, 1'b1, 8'h00);
    chk(active_page, 8'h0F);
    irq(1'b0, 1'b1, 8'h00);
    chk(active_page, 8'h05);
    for (int i = 0; i < 4; i++) begin
      sfr(8'h80 + 8'(16 * i), 9'h100);
    end
    sfr(8'h88, 9'h005);
    bus(1'b1, `CSTP_OFF_PAGE_CTRL, 32'h0);
    irq(1'b1, 1'b0, 8'h0F);
    chk(active_page, 8'h05);
    xm(16'h0010, cstp_pkg::CSTP_TGT_ONCHIP);
    xm(16'h2000, cstp_pkg::CSTP_TGT_OFFCHIP);
    bus(1'b1, `CSTP_OFF_XMOVE_CTRL, 32'h1);
    xm(16'h0010, cstp_pkg::CSTP_TGT_FLASH);
    for (int i = 0; i < 15; i++) begin
      run(tbl[i]);
    end
    bus(1'b0, `CSTP_OFF_STATUS, 32'h0);
    chk(rd[11:4], 8'hC3);
    complete_run();
  end
endmodule
